/* File: key_wake_pkg.sv */
// Constants and carrier types for the key wake unit.
// Assumes a single 20 MHz bus clock and an AXI4-Lite register port.
package key_wake_pkg;

  // ==========================================================================
  // Register map
  // ==========================================================================
  // Printed offsets are not all multiples of four, so they are indices
  localparam logic [7:0] KEY_STATUS_CONTROL_IDX = 8'h1A;
  localparam logic [7:0] KEY_INPUT_ENABLES_IDX  = 8'h1B;
  localparam logic [7:0] KEY_PIN_STATE_IDX      = 8'h1C;
  localparam int         ADDR_W                 = 12;

  // Status and control fields
  localparam int SC_SENS_BIT = 0;
  localparam int SC_MASK_BIT = 1;
  localparam int SC_ACK_BIT  = 2;
  localparam int SC_PEND_BIT = 3;

  // Enable register fields
  localparam int EN_WAKE_BIT = 6;
  localparam int NUM_PINS    = 6;

  localparam logic [7:0]  REG_RESET = 8'h00;
  localparam logic [1:0]  RESP_OKAY = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // ==========================================================================
  // State carrier
  // ==========================================================================
  typedef struct packed {
    logic [NUM_PINS-1:0] sync1;
    logic [NUM_PINS-1:0] sync2;
    logic                all_high;
    logic                pin_latch;
    logic                ack_seen;
    logic                wake_latch;
    logic                sensitivity_select;
    logic                request_mask;
    logic [NUM_PINS-1:0] pin_enable_bit;
    logic                wakeup_timer_enable;
    logic                aw_taken;
    logic                w_taken;
    logic [ADDR_W-1:0]   awaddr;
    logic [7:0]          wdata;
    logic                wstrb0;
    logic                bvalid;
    logic [1:0]          bresp;
    logic                rvalid;
    logic [31:0]         rdata;
    logic [1:0]          rresp;
  } key_state_s;

endpackage : key_wake_pkg

/* File: key_wake_unit.sv */
// Key wake unit: six falling-edge key inputs plus a wake timer request,
// one maskable latched interrupt, registers over AXI4-Lite.
// Assumes pins are asynchronous; vector fetch and break come from the core.
`timescale 1ns/1ps

// What this block does
// RULE_01 - Six key pins, each with its own enable bit.
// RULE_02 - An enabled pin turns its pullup on, whatever the port pullup says.
// RULE_03 - Latch a request when an enabled input falls after all were high.
// RULE_04 - Edge mode: no latch if another enabled input already low.
// RULE_05 - Level mode: request holds until acknowledged and all inputs high.
// RULE_06 - Edge mode: vector fetch or acknowledge clears request at once.
// RULE_07 - Vector fetch of the key vector acts as an internal acknowledge.
// RULE_08 - Writing 1 to acknowledge clears key and wake requests; reads 0.
// RULE_09 - A falling edge after acknowledge latches a fresh request.
// RULE_10 - Wake request cleared only by software acknowledge or reset.
// RULE_11 - Reset clears request and sensitivity even with an input low.
// RULE_12 - Pending flag bit 3 shows any pending request, ignoring mask.
// RULE_13 - Mask bit stops the request reaching the core; reset clears it.
// RULE_14 - Enabled pin is forced to input, overriding its direction bit.
// RULE_15 - Unit runs in wait and stop; unmasked request wakes the core.
// RULE_16 - In break, acknowledge writes ignored unless break clear enable set.
// RULE_17 - Upper four status bits read as zero.
// RULE_18 - Status: sensitivity b0, mask b1, acknowledge b2, pending b3.
// RULE_19 - Enable register: pins in bits 0-5, wake enable bit 6; reset zero.
// RULE_20 - Software masks, enables, acknowledges, then unmasks at init.
// RULE_21 - Software may drive pins high as outputs before enabling them.
// RULE_22 - Each pin passes a two-flop synchroniser before detection.
module key_wake_unit
  import key_wake_pkg::*;
#(
  parameter int PINS = NUM_PINS
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic [PINS-1:0]   port_pins_zero_to_five,
  input  wire logic              wakeup_timer_request,
  input  wire logic              vector_fetch_ack,
  input  wire logic              break_state,
  input  wire logic              break_clear_enable,
  output logic                   key_irq,
  output logic                   wake_core,
  output logic [PINS-1:0]        pullup_force,
  output logic [PINS-1:0]        input_force
);

  // ==========================================================================
  // Elaboration checks
  // ==========================================================================
  if (PINS != NUM_PINS) begin : g_bad_pins
    $error("key_wake_unit supports exactly six key pins");
  end
  if (ADDR_W < 10) begin : g_bad_addr
    $error("address too narrow for the register indices");
  end

  // ==========================================================================
  // Word indices
  // ==========================================================================
  // Word index is the byte address without its two lane bits
  localparam logic [ADDR_W-3:0] STATUS_WORD = (ADDR_W-2)'(KEY_STATUS_CONTROL_IDX);
  localparam logic [ADDR_W-3:0] ENABLE_WORD = (ADDR_W-2)'(KEY_INPUT_ENABLES_IDX);
  localparam logic [ADDR_W-3:0] PINS_WORD   = (ADDR_W-2)'(KEY_PIN_STATE_IDX);

  key_state_s q_q;
  key_state_s n_d;

  logic [PINS-1:0] en_low;
  logic            any_low;
  logic            fall_evt;
  logic            sw_ack;
  logic            ack_any;
  logic            aw_now;
  logic            w_now;
  logic            wr_go;
  logic            rd_go;
  logic [ADDR_W-1:0] wr_addr;
  logic [7:0]      wr_byte;
  logic            wr_lane;
  logic            pending;

  // ==========================================================================
  // Combinational next state
  // ==========================================================================
  always_comb begin
    n_d = q_q;

    // RULE_22 two-flop sync
    n_d.sync1 = port_pins_zero_to_five;
    n_d.sync2 = q_q.sync1;

    en_low  = ~q_q.sync2 & q_q.pin_enable_bit;
    any_low = |en_low;
    n_d.all_high = ~any_low;
    // RULE_03 fall after all high
    // RULE_04 edge blocked when one already low
    fall_evt = any_low & q_q.all_high;

    // AXI write: address and data taken in either order
    aw_now = s_axi_awvalid & ~q_q.aw_taken & ~q_q.bvalid;
    w_now  = s_axi_wvalid & ~q_q.w_taken & ~q_q.bvalid;
    if (aw_now) begin
      n_d.aw_taken = 1'b1;
      n_d.awaddr   = s_axi_awaddr;
    end
    if (w_now) begin
      n_d.w_taken = 1'b1;
      n_d.wdata   = s_axi_wdata[7:0];
      n_d.wstrb0  = s_axi_wstrb[0];
    end
    wr_go   = (q_q.aw_taken | aw_now) & (q_q.w_taken | w_now);
    wr_addr = q_q.aw_taken ? q_q.awaddr : s_axi_awaddr;
    wr_byte = q_q.w_taken ? q_q.wdata : s_axi_wdata[7:0];
    wr_lane = q_q.w_taken ? q_q.wstrb0 : s_axi_wstrb[0];

    // A write to a mapped word with byte lane 0 off changes nothing but still answers OKAY
    sw_ack = 1'b0;
    if (wr_go) begin
      n_d.aw_taken = 1'b0;
      n_d.w_taken  = 1'b0;
      n_d.bvalid   = 1'b1;
      n_d.bresp    = RESP_OKAY;
      if (wr_addr[ADDR_W-1:2] == STATUS_WORD && wr_lane) begin
        n_d.sensitivity_select = wr_byte[SC_SENS_BIT];
        // RULE_13 mask bit write
        n_d.request_mask = wr_byte[SC_MASK_BIT];
        // RULE_16 break protects latch
        sw_ack = wr_byte[SC_ACK_BIT] & (~break_state | break_clear_enable);
      end else if (wr_addr[ADDR_W-1:2] == ENABLE_WORD && wr_lane) begin
        // RULE_01 per-pin enables
        // RULE_19 wake enable bit 6
        n_d.pin_enable_bit      = wr_byte[PINS-1:0];
        n_d.wakeup_timer_enable = wr_byte[EN_WAKE_BIT];
      end else if (wr_addr[ADDR_W-1:2] != ENABLE_WORD &&
                   wr_addr[ADDR_W-1:2] != STATUS_WORD &&
                   wr_addr[ADDR_W-1:2] != PINS_WORD) begin
        n_d.bresp = RESP_SLVERR;
      end
    end
    if (q_q.bvalid && s_axi_bready) begin
      n_d.bvalid = 1'b0;
    end

    // RULE_07 vector fetch acknowledges
    // RULE_08 acknowledge clears both latches
    ack_any = sw_ack | vector_fetch_ack;

    // RULE_06 edge mode clears at once
    // RULE_05 level mode waits for both
    // RULE_09 new fall wins over ack
    // Set wins: a fall in the acknowledge cycle keeps the latch
    if (fall_evt) begin
      n_d.pin_latch = 1'b1;
      n_d.ack_seen  = 1'b0;
    end else if (q_q.pin_latch) begin
      if (!q_q.sensitivity_select) begin
        if (ack_any) begin
          n_d.pin_latch = 1'b0;
        end
      end else begin
        if ((ack_any | q_q.ack_seen) & ~any_low) begin
          n_d.pin_latch = 1'b0;
          n_d.ack_seen  = 1'b0;
        end else if (ack_any) begin
          n_d.ack_seen = 1'b1;
        end
      end
    end
    // Level mode: a low level re-asserts after an ack if inputs stay low
    if (q_q.sensitivity_select && any_low && !q_q.pin_latch && !fall_evt) begin
      n_d.pin_latch = 1'b1;
    end

    // RULE_10 wake cleared by software only
    if (wakeup_timer_request & q_q.wakeup_timer_enable) begin
      n_d.wake_latch = 1'b1;
    end else if (sw_ack) begin
      n_d.wake_latch = 1'b0;
    end

    // Read channel: one answer at a time, one cycle after the address
    // Unmapped reads answer SLVERR with zero data so software sees a clean word
    rd_go = s_axi_arvalid & ~q_q.rvalid;
    if (rd_go) begin
      n_d.rvalid = 1'b1;
      n_d.rresp  = RESP_OKAY;
      n_d.rdata  = 32'h0000_0000;
      if (s_axi_araddr[ADDR_W-1:2] == STATUS_WORD) begin
        // RULE_17 upper bits zero
        // RULE_18 status layout, ack reads 0
        // RULE_12 pending ignores mask
        n_d.rdata[SC_SENS_BIT] = q_q.sensitivity_select;
        n_d.rdata[SC_MASK_BIT] = q_q.request_mask;
        n_d.rdata[SC_PEND_BIT] = q_q.pin_latch | q_q.wake_latch;
      end else if (s_axi_araddr[ADDR_W-1:2] == ENABLE_WORD) begin
        n_d.rdata[PINS-1:0]    = q_q.pin_enable_bit;
        n_d.rdata[EN_WAKE_BIT] = q_q.wakeup_timer_enable;
      end else if (s_axi_araddr[ADDR_W-1:2] == PINS_WORD) begin
        n_d.rdata[PINS-1:0] = q_q.sync2;
      end else begin
        n_d.rresp = RESP_SLVERR;
      end
    end else if (q_q.rvalid && s_axi_rready) begin
      n_d.rvalid = 1'b0;
    end
  end

  // ==========================================================================
  // State register
  // ==========================================================================
  // RULE_11 reset clears latch and sensitivity
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q_q <= '0;
    end else begin
      q_q <= n_d;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign s_axi_awready = ~q_q.aw_taken & ~q_q.bvalid;
  assign s_axi_wready  = ~q_q.w_taken & ~q_q.bvalid;
  assign s_axi_bvalid  = q_q.bvalid;
  assign s_axi_bresp   = q_q.bresp;
  assign s_axi_arready = ~q_q.rvalid;
  assign s_axi_rvalid  = q_q.rvalid;
  assign s_axi_rdata   = q_q.rdata;
  assign s_axi_rresp   = q_q.rresp;

  assign pending = q_q.pin_latch | q_q.wake_latch;
  // RULE_13 mask gates the request
  // RULE_15 unmasked request wakes core
  assign key_irq   = pending & ~q_q.request_mask;
  assign wake_core = pending & ~q_q.request_mask;
  // RULE_02 forced pullup
  assign pullup_force = q_q.pin_enable_bit;
  // RULE_14 forced input direction
  assign input_force  = q_q.pin_enable_bit;

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  irq_mask_gate_a: assert property (q_q.request_mask |-> !key_irq) // RULE_13
    else $error("masked request reached core");
  edge_latch_a: assert property (any_low && q_q.all_high |=> q_q.pin_latch) // RULE_03
    else $error("fall did not latch");
  edge_blocked_a: assert property ($past(any_low) && any_low && !q_q.pin_latch && !q_q.sensitivity_select
                                   |=> !q_q.pin_latch) // RULE_04
    else $error("edge latched while an input already low");
  edge_clear_a: assert property (!q_q.sensitivity_select && q_q.pin_latch && vector_fetch_ack && !fall_evt
                                 |=> !q_q.pin_latch) // RULE_06
    else $error("edge mode request not cleared by fetch");
  level_hold_a: assert property (q_q.sensitivity_select && any_low |=> q_q.pin_latch) // RULE_05
    else $error("level request dropped while input low");
  wake_keep_a: assert property (q_q.wake_latch && !sw_ack |=> q_q.wake_latch) // RULE_10
    else $error("wake request cleared without acknowledge");
  break_protect_a: assert property (break_state && !break_clear_enable |-> !sw_ack) // RULE_16
    else $error("acknowledge acted during protected break");
  status_read_a: assert property (rd_go && s_axi_araddr[ADDR_W-1:2] == STATUS_WORD
                                  |=> s_axi_rdata[7:4] == 4'h0 && !s_axi_rdata[SC_ACK_BIT]
                                      && s_axi_rdata[SC_PEND_BIT] == $past(pending)) // RULE_12
    else $error("status read wrong");
  sync_delay_a: assert property (en_low == (~$past(port_pins_zero_to_five, 2) & q_q.pin_enable_bit)
                                 || $changed(q_q.pin_enable_bit)) // RULE_22
    else $error("pin sync depth not two");

  // ==========================================================================
  // Latch and register checks
  // ==========================================================================
  // Reset check runs while reset is low, so it carries no disable
  reset_clear_a: assert property (disable iff (1'b0) !aresetn // RULE_11
                                  |=> !q_q.pin_latch && !q_q.wake_latch && !q_q.sensitivity_select)
    else $error("reset left a request or sensitivity set");
  level_keep_a: assert property (q_q.sensitivity_select && q_q.pin_latch // RULE_05
                                 && !ack_any && !q_q.ack_seen |=> q_q.pin_latch)
    else $error("level request dropped without acknowledge");
  ack_clear_a: assert property (!q_q.sensitivity_select && q_q.pin_latch && sw_ack // RULE_08
                                && !fall_evt |=> !q_q.pin_latch)
    else $error("acknowledge did not clear edge request");
  ack_wake_a: assert property (sw_ack && !(wakeup_timer_request && q_q.wakeup_timer_enable) // RULE_08
                               |=> !q_q.wake_latch)
    else $error("acknowledge did not clear wake request");
  fresh_edge_a: assert property (sw_ack && fall_evt // RULE_09
                                 |=> q_q.pin_latch)
    else $error("fall in acknowledge cycle was lost");
  wake_set_a: assert property (wakeup_timer_request && q_q.wakeup_timer_enable // RULE_10
                               |=> q_q.wake_latch)
    else $error("wake request not latched");
  unmask_wake_a: assert property (pending && !q_q.request_mask // RULE_15
                                  |-> wake_core && key_irq)
    else $error("unmasked request did not reach core");
  status_write_a: assert property (wr_go && wr_addr[ADDR_W-1:2] == STATUS_WORD && wr_lane // RULE_18
                                   |=> q_q.sensitivity_select == $past(wr_byte[SC_SENS_BIT])
                                       && q_q.request_mask == $past(wr_byte[SC_MASK_BIT]))
    else $error("status write did not land");
  enable_write_a: assert property (wr_go && wr_addr[ADDR_W-1:2] == ENABLE_WORD && wr_lane // RULE_14
                                   |=> input_force == $past(wr_byte[PINS-1:0])
                                       && pullup_force == $past(wr_byte[PINS-1:0]))
    else $error("enable write did not force pins");
  pin_read_a: assert property (rd_go && s_axi_araddr[ADDR_W-1:2] == PINS_WORD // RULE_22
                               |=> s_axi_rdata[PINS-1:0] == $past(q_q.sync2))
    else $error("pin state read wrong");

  // ==========================================================================
  // Bus answer checks
  // ==========================================================================
  bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready // RULE_18
                                  |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready // RULE_18
                                  |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  slverr_read_a: assert property (rd_go && s_axi_araddr[ADDR_W-1:2] != STATUS_WORD // RULE_17
                                  && s_axi_araddr[ADDR_W-1:2] != ENABLE_WORD
                                  && s_axi_araddr[ADDR_W-1:2] != PINS_WORD
                                  |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
    else $error("unmapped read not refused");

  // ==========================================================================
  // Coverage
  // ==========================================================================
  fall_cov_c:  cover property (fall_evt);
  level_cov_c: cover property (q_q.sensitivity_select && q_q.ack_seen ##1 !q_q.pin_latch);
  wake_cov_c:  cover property (q_q.wake_latch && sw_ack);
  mask_cov_c:  cover property (q_q.request_mask && pending);
  break_cov_c: cover property (break_state && break_clear_enable && sw_ack);

endmodule : key_wake_unit

/* File: key_switches.sv */
// Partner model: six keys that short the port pins to ground when pressed.
// Assumes the bench chooses which keys are held; open keys sit at the pull level.
`timescale 1ns/1ps
// ==========================================================================
// Key contacts
// ==========================================================================
module key_switches (
  input  wire logic [5:0] pressed,
  output logic      [5:0] pins
);
  // keys open before enables set
  // An open contact shows its pull level, never a stale driven value
  assign pins = ~pressed;
endmodule : key_switches

/* File: test_key_wake_unit.sv */
// Self-checking bench for the key wake unit and its AXI4-Lite registers.
// Assumes the slave answers each request within a few cycles.
`timescale 1ns/1ps
module test_key_wake_unit;
  import key_wake_pkg::*;
  typedef struct packed {
    logic [11:0] a;
    logic [7:0]  w;
    logic [1:0]  br;
    logic [7:0]  r;
    logic [1:0]  rr;
  } row_s;
  logic        aclk = 0;
  logic        aresetn = 0;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, dat;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [5:0]  pressed = 0, port_pins_zero_to_five, pullup_force, input_force;
  logic        wakeup_timer_request = 0, vector_fetch_ack = 0, break_state = 0, break_clear_enable = 0;
  logic        key_irq, wake_core;
  int          fail_count = 0;
  int          num_checks = 0;
  row_s        rows [3];

  always #25 aclk = ~aclk;

  key_switches u_keys (.pressed, .pins(port_pins_zero_to_five));
  key_wake_unit u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .port_pins_zero_to_five, .wakeup_timer_request, .vector_fetch_ack, .break_state,
    .break_clear_enable, .key_irq, .wake_core, .pullup_force, .input_force);

  // ==========================================================================
  // Bus and check tasks
  // ==========================================================================
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [7:0] d, output logic [1:0] r);
    int n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      r = s_axi_bresp;
    end while (s_axi_bvalid !== 1'b1 && n < 20);
    if (s_axi_bvalid !== 1'b1) fail_count++;
    s_axi_bready <= 1'b0;
    // Let one edge pass so a following request never re-drives in this step
    @(posedge aclk);
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [1:0] r, output logic [31:0] d);
    int n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      r = s_axi_rresp;
      d = s_axi_rdata;
    end while (s_axi_rvalid !== 1'b1 && n < 20);
    if (s_axi_rvalid !== 1'b1) fail_count++;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask : rd

  task automatic st(input logic [31:0] e);
    rd(12'h068, rsp, dat);
    chk(dat, e);
  endtask : st

  task automatic irq(input logic e);
    chk({wake_core, key_irq}, {2{e}});
  endtask : irq

  // Five edges cover the two-flop synchroniser plus the latch
  task automatic key(input logic [5:0] p);
    pressed <= p;
    repeat (5) @(posedge aclk);
  endtask : key

  task automatic pulse(input logic w);
    if (w) wakeup_timer_request <= 1'b1;
    else vector_fetch_ack <= 1'b1;
    @(posedge aclk);
    wakeup_timer_request <= 1'b0;
    vector_fetch_ack <= 1'b0;
    repeat (3) @(posedge aclk);
  endtask : pulse

  task automatic results;
    $display("checks %0d, mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : results

  // ==========================================================================
  // Sequence
  // ==========================================================================
  initial begin
    rows = '{'{12'h06C, 8'h7F, RESP_OKAY, 8'h7F, RESP_OKAY},
             '{12'h068, 8'hF7, RESP_OKAY, 8'h03, RESP_OKAY},
             '{12'h074, 8'h55, RESP_SLVERR, 8'h00, RESP_SLVERR}};
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    st(32'h0);
    rd(12'h06C, rsp, dat);
    chk(dat, 32'h0);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w, rsp);
      chk(rsp, rows[i].br);
      rd(rows[i].a, rsp, dat);
      chk(rsp, rows[i].rr);
      chk(dat, rows[i].r);
    end
    chk({pullup_force, input_force}, 12'hFFF);
    wr(12'h068, 8'h02, rsp);
    wr(12'h06C, 8'h7F, rsp);
    wr(12'h068, 8'h06, rsp);
    irq(0);
    wr(12'h068, 8'h04, rsp);
    key(6'h01);
    irq(1);
    rd(12'h070, rsp, dat);
    chk(dat, 32'h3E);
    st(32'h08);
    wr(12'h068, 8'h04, rsp);
    irq(0);
    key(6'h03);
    irq(0);
    key(6'h00);
    key(6'h04);
    irq(1);
    pulse(0);
    irq(0);
    wr(12'h068, 8'h02, rsp);
    key(6'h00);
    key(6'h08);
    irq(0);
    st(32'h0A);
    wr(12'h068, 8'h00, rsp);
    irq(1);
    key(6'h00);
    wr(12'h068, 8'h05, rsp);
    key(6'h10);
    wr(12'h068, 8'h05, rsp);
    irq(1);
    key(6'h00);
    irq(0);
    key(6'h20);
    key(6'h00);
    irq(1);
    wr(12'h068, 8'h05, rsp);
    irq(0);
    wr(12'h068, 8'h04, rsp);
    pulse(1);
    irq(1);
    pulse(0);
    irq(1);
    wr(12'h068, 8'h04, rsp);
    irq(0);
    pulse(1);
    break_state <= 1'b1;
    wr(12'h068, 8'h04, rsp);
    irq(1);
    break_clear_enable <= 1'b1;
    wr(12'h068, 8'h04, rsp);
    break_state <= 1'b0;
    break_clear_enable <= 1'b0;
    repeat (2) @(posedge aclk);
    irq(0);
    wr(12'h068, 8'h01, rsp);
    key(6'h01);
    irq(1);
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    irq(0);
    st(32'h0);
    results;
  end

  initial begin
    repeat (3000) @(posedge aclk);
    fail_count++;
    results;
  end
endmodule : test_key_wake_unit
